// *** rtl/eiu_pin_sampler.sv ***
`timescale 1ns/1ps
module eiu_pin_sampler (
    // Clock and reset
    input  wire logic                             clk,
    input  wire logic                             resetn,
    // Raw pins, outside the clock domain
    input  wire logic [eiu_pkg::EIU_NUM_PINS-1:0] raw_pins,
    // Synchronised levels and edges
    eiu_pins_if.src                               pins
);
    import eiu_pkg::*;

    typedef struct packed {
        logic [EIU_NUM_PINS-1:0] s1;
        logic [EIU_NUM_PINS-1:0] s2;
        logic [EIU_NUM_PINS-1:0] prev;
    } eiu_samp_t;

    eiu_samp_t r;
    eiu_samp_t next_r;

    // Idle-high reset avoids a false edge on release with pulled-up pins
    always_comb begin
        next_r      = r;
        next_r.s1   = raw_pins;
        next_r.s2   = r.s1;
        next_r.prev = r.s2;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '{default: {EIU_NUM_PINS{EIU_RST_PIN}}};
        end else begin
            r <= next_r;
        end
    end

    assign pins.level = r.s2;
    assign pins.rise  = r.s2 & ~r.prev;
    assign pins.fall  = ~r.s2 & r.prev;

    property p_sync_depth;
        @(posedge clk) disable iff (!resetn)
        $past(resetn, 3) |-> pins.level == $past(raw_pins, 2);
    endproperty
    a_sync_depth: assert property (p_sync_depth) else $error("pin level not two stages behind raw");

    property p_edge_pair;
        @(posedge clk) disable iff (!resetn)
        (pins.rise[0] || pins.fall[0]) |-> pins.level[0] != $past(pins.level[0]);
    endproperty
    a_edge_pair: assert property (p_edge_pair) else $error("edge without level change");
endmodule

// *** rtl/eiu_pins_if.sv ***
`timescale 1ns/1ps
interface eiu_pins_if;
    import eiu_pkg::*;
    logic [EIU_NUM_PINS-1:0] level;
    logic [EIU_NUM_PINS-1:0] rise;
    logic [EIU_NUM_PINS-1:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// *** rtl/eiu_pkg.sv ***
package eiu_pkg;
    // Register byte addresses on the plain register port
    localparam logic [7:0] EIU_ADDR_SENSE_LO = 8'h69;
    localparam logic [7:0] EIU_ADDR_SENSE_HI = 8'h6A;
    localparam logic [7:0] EIU_ADDR_EN_MASK  = 8'h3D;
    localparam logic [7:0] EIU_ADDR_FLAGS    = 8'h3C;
    localparam logic [7:0] EIU_ADDR_PC_EN    = 8'h68;
    localparam logic [7:0] EIU_ADDR_PC_FLAGS = 8'h3B;
    localparam logic [7:0] EIU_ADDR_PC_MASK0 = 8'h6B;
    localparam logic [7:0] EIU_ADDR_PC_MASK1 = 8'h6C;
    localparam logic [7:0] EIU_ADDR_PC_MASK2 = 8'h6D;

    // Reset values
    localparam logic [7:0] EIU_RST_BYTE = 8'h00;
    localparam logic       EIU_RST_PIN  = 1'b1;

    // Pin counts and field layout
    localparam int EIU_NUM_DED    = 8;
    localparam int EIU_NUM_CHG    = 9;
    localparam int EIU_NUM_PINS   = EIU_NUM_DED + EIU_NUM_CHG;
    localparam int EIU_SENSE_W    = 2;
    localparam int EIU_PINS_PER_REG = 4;
    localparam int EIU_CLK_GATED_FIRST = 4;

    // Sense field encodings
    localparam logic [1:0] EIU_SENSE_LOW  = 2'h0;
    localparam logic [1:0] EIU_SENSE_ANY  = 2'h1;
    localparam logic [1:0] EIU_SENSE_FALL = 2'h2;
    localparam logic [1:0] EIU_SENSE_RISE = 2'h3;

    // Timing: least pulse width that must be caught
    localparam int EIU_CLK_PERIOD_NS = 100;
    localparam int EIU_MIN_PULSE_NS  = 50;
    localparam int EIU_MIN_PULSE_CYC_RAW = (EIU_MIN_PULSE_NS + EIU_CLK_PERIOD_NS - 1) / EIU_CLK_PERIOD_NS;
    localparam int EIU_MIN_PULSE_CYC = (EIU_MIN_PULSE_CYC_RAW < 1) ? 1 : EIU_MIN_PULSE_CYC_RAW;
endpackage

// *** rtl/eiu_top.sv ***
`timescale 1ns/1ps
// How it works
// - Pins driven as outputs still raise enabled interrupts; pin values are observed directly.
// - Group 0 requests on any enabled change pin 7..0 toggle; group 1 on pin 8.
// - Change pins 9..23, group 2 request and mask do nothing.
// - Only pins set in group 0/1 change masks contribute to their request.
// - Change detection needs no gated I/O clock, so it can wake from deep sleep.
// - Low-level sensing keeps the enabled request asserted while the pin is low.
// - Edges on dedicated pins 7..4 are recognised only while the I/O clock runs.
// - Low level on all pins and edges on pins 3..0 work without the I/O clock.
// - I/O clock stops in sleep other than Idle, disabling clocked detection.
// - Level wake needs the level held through start-up, else no interrupt.
// - Dedicated request needs global enable and the pin's enable-mask bit.
// - Pulses at least one 100 ns clock period wide produce a request; narrower ones can fall between samples and be missed.
// - Sense field: 0 low level, 1 any edge, 2 falling, 3 rising.
// - Rewriting a sense field may raise a spurious request; not suppressed.
// - Pins 3..0 sense in register A, 7..4 in B, two bits each.
// - Each dedicated pin has an enable bit gated with the global enable.
// - Flags set on trigger, clear on handler or write-one, zero under level sense.
module eiu_top (
    // Clock and reset
    input  wire logic                             clk,
    input  wire logic                             resetn,
    // Register port
    input  wire logic [7:0]                       addr,
    input  wire logic [7:0]                       wr_data,
    input  wire logic                             wr_en,
    input  wire logic                             rd_en,
    output logic      [7:0]                       rd_data,
    // External pins
    input  wire logic [eiu_pkg::EIU_NUM_DED-1:0]  dedicated_irq_pins,
    input  wire logic [eiu_pkg::EIU_NUM_CHG-1:0]  pin_change_pins,
    // Core side
    input  wire logic                             global_irq_enable,
    input  wire logic                             io_clock_running,
    input  wire logic [eiu_pkg::EIU_NUM_DED-1:0]  ext_irq_ack,
    input  wire logic [1:0]                       change_ack,
    // Requests
    output logic      [eiu_pkg::EIU_NUM_DED-1:0]  ext_irq_request,
    output logic                                  change_group0_request,
    output logic                                  change_group1_request,
    output logic                                  change_group2_request,
    output logic                                  wake_request
);
    import eiu_pkg::*;

    typedef struct packed {
        logic [7:0] ext_irq_sense_low_pins;
        logic [7:0] ext_irq_sense_high_pins;
        logic [7:0] ext_irq_enable_mask;
        logic [7:0] ext_irq_flag_register;
        logic [1:0] change_enable;
        logic [1:0] change_flags;
        logic [7:0] change_group0_mask;
        logic       change_group1_mask;
        logic [7:0] rd_data;
        logic [7:0] ext_req;
        logic [1:0] chg_req;
        logic       wake;
    } eiu_regs_t;

    eiu_regs_t r;
    eiu_regs_t next_r;

    eiu_pins_if pins_if ();

    eiu_pin_sampler u_sampler (
        .clk      (clk),
        .resetn   (resetn),
        .raw_pins ({pin_change_pins, dedicated_irq_pins}),
        .pins     (pins_if.src)
    );

    // Pin n lives at bits 2n+1:2n modulo four of its register
    function automatic logic [1:0] pin_sense_select(input logic [7:0] lo, input logic [7:0] hi, input int n);
        logic [7:0] src;
        int         pos;
        src = (n < EIU_PINS_PER_REG) ? lo : hi;
        pos = (n % EIU_PINS_PER_REG) * EIU_SENSE_W;
        return src[pos +: EIU_SENSE_W];
    endfunction

    function automatic logic sense_hit(input logic [1:0] sense, input logic rise, input logic fall);
        case (sense)
            EIU_SENSE_ANY:  return rise | fall;
            EIU_SENSE_FALL: return fall;
            EIU_SENSE_RISE: return rise;
            default:        return 1'b0;
        endcase
    endfunction

    always_comb begin
        logic [1:0] sense;
        logic       edge_ok;
        logic       hit;
        logic       clr;
        logic [8:0] chg;
        logic       grp0_hit;
        logic       grp1_hit;
        logic [1:0] chg_clr;
        logic       lvl_active;
        sense      = EIU_SENSE_LOW;
        edge_ok    = 1'b0;
        hit        = 1'b0;
        clr        = 1'b0;
        lvl_active = 1'b0;
        chg        = 9'h000;
        grp0_hit   = 1'b0;
        grp1_hit   = 1'b0;
        chg_clr    = 2'h0;
        next_r     = r;

        if (wr_en) begin
            case (addr)
                EIU_ADDR_SENSE_LO: next_r.ext_irq_sense_low_pins  = wr_data;
                EIU_ADDR_SENSE_HI: next_r.ext_irq_sense_high_pins = wr_data;
                EIU_ADDR_EN_MASK:  next_r.ext_irq_enable_mask     = wr_data;
                EIU_ADDR_PC_EN:    next_r.change_enable           = wr_data[1:0];
                EIU_ADDR_PC_MASK0: next_r.change_group0_mask      = wr_data;
                EIU_ADDR_PC_MASK1: next_r.change_group1_mask      = wr_data[0];
                default: ;
            endcase
        end

        // Dedicated pins; edges seen even if the pin is driven as an output
        for (int i = 0; i < EIU_NUM_DED; i++) begin
            sense   = pin_sense_select(r.ext_irq_sense_low_pins, r.ext_irq_sense_high_pins, i);
            edge_ok = (i < EIU_CLK_GATED_FIRST) || io_clock_running;
            hit     = edge_ok && sense_hit(sense, pins_if.rise[i], pins_if.fall[i]);
            clr     = ext_irq_ack[i] || (wr_en && addr == EIU_ADDR_FLAGS && wr_data[i]);
            if (sense == EIU_SENSE_LOW) begin
                next_r.ext_irq_flag_register[i] = 1'b0;
                next_r.ext_req[i] = global_irq_enable && r.ext_irq_enable_mask[i]
                                    && !pins_if.level[i];
                lvl_active = lvl_active || (r.ext_irq_enable_mask[i] && !pins_if.level[i]);
            end else begin
                // A new trigger wins over a clear in the same cycle
                next_r.ext_irq_flag_register[i] = hit || (r.ext_irq_flag_register[i] && !clr);
                next_r.ext_req[i] = global_irq_enable && r.ext_irq_enable_mask[i]
                                    && r.ext_irq_flag_register[i];
            end
        end

        // Pin-change groups; pins 9..23 do not exist here
        chg      = pins_if.rise[EIU_NUM_PINS-1:EIU_NUM_DED] | pins_if.fall[EIU_NUM_PINS-1:EIU_NUM_DED];
        grp0_hit = |(r.change_group0_mask & chg[7:0]);
        grp1_hit = r.change_group1_mask && chg[8];
        chg_clr  = change_ack | ((wr_en && addr == EIU_ADDR_PC_FLAGS) ? wr_data[1:0] : 2'h0);
        next_r.change_flags[0] = grp0_hit || (r.change_flags[0] && !chg_clr[0]);
        next_r.change_flags[1] = grp1_hit || (r.change_flags[1] && !chg_clr[1]);
        for (int g = 0; g < 2; g++) begin
            next_r.chg_req[g] = global_irq_enable && r.change_enable[g] && r.change_flags[g];
        end

        // Wake does not need the global enable, only the per-source enables
        next_r.wake = lvl_active || |(r.ext_irq_enable_mask & r.ext_irq_flag_register)
                      || |(r.change_enable & r.change_flags);

        next_r.rd_data = 8'h00;
        if (rd_en) begin
            case (addr)
                EIU_ADDR_SENSE_LO: next_r.rd_data = r.ext_irq_sense_low_pins;
                EIU_ADDR_SENSE_HI: next_r.rd_data = r.ext_irq_sense_high_pins;
                EIU_ADDR_EN_MASK:  next_r.rd_data = r.ext_irq_enable_mask;
                EIU_ADDR_FLAGS:    next_r.rd_data = r.ext_irq_flag_register;
                EIU_ADDR_PC_EN:    next_r.rd_data = {6'h00, r.change_enable};
                EIU_ADDR_PC_FLAGS: next_r.rd_data = {6'h00, r.change_flags};
                EIU_ADDR_PC_MASK0: next_r.rd_data = r.change_group0_mask;
                EIU_ADDR_PC_MASK1: next_r.rd_data = {7'h00, r.change_group1_mask};
                default:           next_r.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '{default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign rd_data               = r.rd_data;
    assign ext_irq_request       = r.ext_req;
    assign change_group0_request = r.chg_req[0];
    assign change_group1_request = r.chg_req[1];
    assign change_group2_request = 1'b0;   // Group 2 has no pins behind it
    assign wake_request          = r.wake;

    property p_level_req;
        @(posedge clk) disable iff (!resetn)
        (global_irq_enable && r.ext_irq_enable_mask[0] && r.ext_irq_sense_low_pins[1:0] == EIU_SENSE_LOW
         && !pins_if.level[0]) |=> ext_irq_request[0];
    endproperty
    a_level_req: assert property (p_level_req) else $error("low level did not request");

    property p_level_flag;
        @(posedge clk) disable iff (!resetn)
        (r.ext_irq_sense_high_pins[7:6] == EIU_SENSE_LOW) |=> !r.ext_irq_flag_register[7];
    endproperty
    a_level_flag: assert property (p_level_flag) else $error("flag set under level sense");

    property p_gie_gate;
        @(posedge clk) disable iff (!resetn)
        !global_irq_enable |=> ext_irq_request == 8'h00 && !change_group0_request && !change_group1_request;
    endproperty
    a_gie_gate: assert property (p_gie_gate) else $error("request without global enable");

    property p_mask_gate;
        @(posedge clk) disable iff (!resetn)
        !r.ext_irq_enable_mask[2] |=> !ext_irq_request[2];
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("request without enable bit");

    property p_group2;
        @(posedge clk) disable iff (!resetn)
        (rd_en && addr == EIU_ADDR_PC_MASK2) |=> rd_data == 8'h00 && !change_group2_request;
    endproperty
    a_group2: assert property (p_group2) else $error("group 2 mask or request not inert");

    property p_grp0_set;
        @(posedge clk) disable iff (!resetn)
        |(r.change_group0_mask & (pins_if.rise[15:8] | pins_if.fall[15:8])) |=> r.change_flags[0];
    endproperty
    a_grp0_set: assert property (p_grp0_set) else $error("masked change not flagged");

    property p_grp0_quiet;
        @(posedge clk) disable iff (!resetn)
        (!r.change_flags[0] && !(|(r.change_group0_mask & (pins_if.rise[15:8] | pins_if.fall[15:8]))))
        |=> !r.change_flags[0];
    endproperty
    a_grp0_quiet: assert property (p_grp0_quiet) else $error("unmasked pin set group flag");

    property p_gated_edge;
        @(posedge clk) disable iff (!resetn)
        (!io_clock_running && !r.ext_irq_flag_register[4] && r.ext_irq_sense_high_pins[1:0] != EIU_SENSE_LOW)
        |=> !r.ext_irq_flag_register[4];
    endproperty
    a_gated_edge: assert property (p_gated_edge) else $error("edge on pin 4 without I/O clock");

    property p_async_edge;
        @(posedge clk) disable iff (!resetn)
        (r.ext_irq_sense_low_pins[1:0] == EIU_SENSE_FALL && pins_if.fall[0]) |=> r.ext_irq_flag_register[0];
    endproperty
    a_async_edge: assert property (p_async_edge) else $error("falling edge on pin 0 missed");

    property p_w1c;
        @(posedge clk) disable iff (!resetn)
        (wr_en && addr == EIU_ADDR_FLAGS && wr_data[1] && !pins_if.rise[1] && !pins_if.fall[1])
        |=> !r.ext_irq_flag_register[1];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

    property p_level_drop;
        @(posedge clk) disable iff (!resetn)
        (r.ext_irq_sense_low_pins[1:0] == EIU_SENSE_LOW && pins_if.level[0]) |=> !ext_irq_request[0];
    endproperty
    a_level_drop: assert property (p_level_drop) else $error("level request outlived the low level");

    property p_edge_req;
        @(posedge clk) disable iff (!resetn)
        (global_irq_enable && r.ext_irq_enable_mask[1] && r.ext_irq_sense_low_pins[3:2] != EIU_SENSE_LOW
         && r.ext_irq_flag_register[1]) |=> ext_irq_request[1];
    endproperty
    a_edge_req: assert property (p_edge_req) else $error("pending enabled flag did not request");

    property p_any_edge;
        @(posedge clk) disable iff (!resetn)
        (r.ext_irq_sense_low_pins[3:2] == EIU_SENSE_ANY && (pins_if.rise[1] || pins_if.fall[1]))
        |=> r.ext_irq_flag_register[1];
    endproperty
    a_any_edge: assert property (p_any_edge) else $error("edge on pin 1 missed in any-edge mode");

    property p_fall_only;
        @(posedge clk) disable iff (!resetn)
        (r.ext_irq_sense_low_pins[5:4] == EIU_SENSE_FALL && !r.ext_irq_flag_register[2] && !pins_if.fall[2])
        |=> !r.ext_irq_flag_register[2];
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("pin 2 flagged without a falling edge");

    property p_rise_only;
        @(posedge clk) disable iff (!resetn)
        (r.ext_irq_sense_low_pins[7:6] == EIU_SENSE_RISE && !r.ext_irq_flag_register[3] && !pins_if.rise[3])
        |=> !r.ext_irq_flag_register[3];
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("pin 3 flagged without a rising edge");

    property p_gated_hit;
        @(posedge clk) disable iff (!resetn)
        (io_clock_running && r.ext_irq_sense_high_pins[5:4] == EIU_SENSE_FALL && pins_if.fall[6])
        |=> r.ext_irq_flag_register[6];
    endproperty
    a_gated_hit: assert property (p_gated_hit) else $error("edge on pin 6 missed with I/O clock");

    property p_ack_clr;
        @(posedge clk) disable iff (!resetn)
        (ext_irq_ack[3] && !pins_if.rise[3] && !pins_if.fall[3]) |=> !r.ext_irq_flag_register[3];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("handler entry did not clear flag");

    property p_wake_lvl;
        @(posedge clk) disable iff (!resetn)
        (r.ext_irq_enable_mask[4] && r.ext_irq_sense_high_pins[1:0] == EIU_SENSE_LOW && !pins_if.level[4])
        |=> wake_request;
    endproperty
    a_wake_lvl: assert property (p_wake_lvl) else $error("low level on pin 4 did not wake");

    property p_grp1_set;
        @(posedge clk) disable iff (!resetn)
        (r.change_group1_mask && (pins_if.rise[16] || pins_if.fall[16])) |=> r.change_flags[1];
    endproperty
    a_grp1_set: assert property (p_grp1_set) else $error("masked change on pin 8 not flagged");

    property p_grp1_quiet;
        @(posedge clk) disable iff (!resetn)
        (!r.change_group1_mask && !r.change_flags[1]) |=> !r.change_flags[1];
    endproperty
    a_grp1_quiet: assert property (p_grp1_quiet) else $error("unmasked pin 8 set group flag");

    property p_chg0_req;
        @(posedge clk) disable iff (!resetn)
        (global_irq_enable && r.change_enable[0] && r.change_flags[0]) |=> change_group0_request;
    endproperty
    a_chg0_req: assert property (p_chg0_req) else $error("group 0 flag did not request");

    property p_chg1_req;
        @(posedge clk) disable iff (!resetn)
        (global_irq_enable && r.change_enable[1] && r.change_flags[1]) |=> change_group1_request;
    endproperty
    a_chg1_req: assert property (p_chg1_req) else $error("group 1 flag did not request");

    property p_rd_sense;
        @(posedge clk) disable iff (!resetn)
        (rd_en && addr == EIU_ADDR_SENSE_HI) |=> rd_data == $past(r.ext_irq_sense_high_pins);
    endproperty
    a_rd_sense: assert property (p_rd_sense) else $error("sense register B read back wrong");

    property p_rd_idle;
        @(posedge clk) disable iff (!resetn)
        !rd_en |=> rd_data == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data stood past its cycle");
endmodule

// *** sim/eiu_core_model.sv ***
`timescale 1ns/1ps
module eiu_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Handler control from the bench
    input  wire logic       accept,
    input  wire logic       slow,
    // Requests in, handler entry out
    input  wire logic [9:0] req,
    output logic      [9:0] ack
);
    logic [2:0] cnt;
    logic [1:0] hold;

    // A request is taken only once it has stood through the running instruction
    // Hold-off after entry lets the request fall before another source is served
    always_ff @(posedge clk) begin
        ack <= 10'h000;
        if (!resetn || !accept || hold != 2'h0 || req == 10'h000) begin
            cnt  <= 3'h0;
            hold <= (!resetn || hold == 2'h0) ? 2'h0 : hold - 2'h1;
        end else if (cnt == (slow ? 3'h5 : 3'h1)) begin
            ack  <= req & (~req + 10'h001);
            cnt  <= 3'h0;
            hold <= 2'h3;
        end else begin
            cnt <= cnt + 3'h1;
        end
    end
endmodule

// *** sim/eiu_top_tb.sv ***
`timescale 1ns/1ps
module eiu_top_tb;
    import eiu_pkg::*;
    logic       clk;
    logic       resetn;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rd_data;
    logic [7:0] ded;
    logic [8:0] chg;
    logic       gie;
    logic       io_run;
    logic [7:0] ext_irq_ack;
    logic [1:0] change_ack;
    logic [7:0] ext_irq_request;
    logic       change_group0_request;
    logic       change_group1_request;
    logic       change_group2_request;
    logic       wake_request;
    logic       accept;
    logic       slow;
    logic       rd_d1;
    logic [9:0] req_all;
    logic [9:0] ack_all;
    logic [7:0] exp_q[$];
    int         n_mismatch;
    int         cmp_count;
    int         seed;
    int         i;
    int         p;
    logic [1:0] m;
    logic [7:0] v;
    logic [7:0] a;

    assign req_all     = {change_group1_request, change_group0_request, ext_irq_request};
    assign ext_irq_ack = ack_all[7:0];
    assign change_ack  = ack_all[9:8];

    eiu_top dut (.clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .dedicated_irq_pins(ded), .pin_change_pins(chg), .global_irq_enable(gie),
        .io_clock_running(io_run), .ext_irq_ack(ext_irq_ack), .change_ack(change_ack),
        .ext_irq_request(ext_irq_request), .change_group0_request(change_group0_request),
        .change_group1_request(change_group1_request), .change_group2_request(change_group2_request),
        .wake_request(wake_request));

    eiu_core_model core (.clk(clk), .resetn(resetn), .accept(accept), .slow(slow), .req(req_all), .ack(ack_all));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        addr    <= ad;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask

    // Expected read data is queued here and compared by the monitor below
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        addr  <= ad;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input int b, input logic e);
        @(negedge clk);
        check({7'h00, req_all[b]}, {7'h00, e});
        @(posedge clk);
    endtask

    // Handler entry through the core model; bounded so a stuck request cannot hang the run
    task automatic serve(input int b);
        int k;
        k      = 0;
        accept <= 1'b1;
        do begin
            @(negedge clk);
            k++;
        end while (req_all[b] !== 1'b0 && k < 16);
        @(posedge clk);
        accept <= 1'b0;
        if (k == 16) begin
            n_mismatch++;
            results();
        end
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (rd_d1) begin
            check(rd_data, exp_q.pop_front());
        end
        rd_d1 <= rd_en;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end

    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        seed = 50;
        rd_d1 = 1'b0;
        {addr, wr_data, wr_en, rd_en, gie, io_run, accept, slow} = '0;
        ded = 8'hFF;
        chg = 9'h1FF;
        resetn = 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(EIU_ADDR_SENSE_LO, EIU_RST_BYTE);
        rd(EIU_ADDR_SENSE_HI, EIU_RST_BYTE);
        for (i = 0; i < 2; i++) begin
            v = 8'($random(seed));
            a = (i == 0) ? EIU_ADDR_SENSE_LO : EIU_ADDR_SENSE_HI;
            wr(a, v);
            rd(a, v);
            wr(a, 8'h00);
        end
        wr(EIU_ADDR_PC_MASK2, 8'hFF);
        rd(EIU_ADDR_PC_MASK2, 8'h00);
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00);
        gie <= 1'b1;
        // Each pin gets sense mode p%4, so both registers and all four modes are set
        for (p = 0; p < 8; p++) begin
            m = 2'(p % 4);
            a = (p < 4) ? EIU_ADDR_SENSE_LO : EIU_ADDR_SENSE_HI;
            wr(EIU_ADDR_EN_MASK, 8'h00);
            wr(a, 8'(m) << (2 * (p % 4)));
            wr(EIU_ADDR_FLAGS, 8'hFF);
            wr(EIU_ADDR_EN_MASK, 8'h01 << p);
            io_run <= 1'b0;
            if (p >= 4 && m != 2'h0) begin
                ded[p] <= 1'b0;
                wait_n(3);
                ded[p] <= 1'b1;
                wait_n(6);
                chk(p, 1'b0);
                io_run <= 1'b1;
            end
            ded[p] <= 1'b0;
            wait_n(6);
            chk(p, m != 2'h3);
            if (p == 0) begin
                gie <= 1'b0;
                wait_n(3);
                chk(0, 1'b0);
                @(negedge clk);
                check({7'h00, wake_request}, 8'h01);
                @(posedge clk);
                gie <= 1'b1;
            end
            ded[p] <= 1'b1;
            wait_n(6);
            chk(p, m != 2'h0);
            rd(EIU_ADDR_FLAGS, (m != 2'h0) ? (8'h01 << p) : 8'h00);
            slow <= p[0];
            serve(p);
            rd(EIU_ADDR_FLAGS, 8'h00);
        end
        // Change pins run with the I/O clock stopped
        io_run <= 1'b0;
        wr(EIU_ADDR_PC_EN, 8'h03);
        v = 8'($random(seed));
        wr(EIU_ADDR_PC_MASK0, v);
        wr(EIU_ADDR_PC_MASK1, 8'h01);
        for (i = 0; i < 9; i++) begin
            chg[i] <= ~chg[i];
            wait_n(6);
            @(negedge clk);
            check({5'h00, change_group2_request, req_all[9:8]}, {6'h00, i == 8, i < 8 && v[i % 8]});
            @(posedge clk);
            rd(EIU_ADDR_PC_FLAGS, {6'h00, i == 8, i < 8 && v[i % 8]});
            serve((i == 8) ? 9 : 8);
        end
        if (exp_q.size() != 0) begin
            n_mismatch++;
        end
        results();
    end
endmodule
